// ---- hdl/acr_readout.sv ----
// Operation
// - chain bit turns status pin into input
// - chain input delayed 16 or 24 clocks
// - own result is first word
// - later words carry upstream data in order
// - without upstream, own result repeats
// - toggled chip select reloads own result
// - no convert start keeps previous result
// - untagged read is 16 clocks
// - tagged unchained read: data, tag, zeros
// - tagged chained read is 24 clocks
// - power-on and soft reset combined
// - reset sets config bits to ones
// - first frame after reset is ones
// - reset returns state machine to idle
// - config bit five selects pin role
// - tag follows lsb at seventeenth clock
// - tag is input channel number
// - output released when chip select rises
module acr_readout
    import acr_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    // configuration port
    input  wire logic                     cfgWrite,
    input  wire logic [acr_pkg::CFG_W-1:0] cfgData,
    output logic      [acr_pkg::CFG_W-1:0] configRegister,
    // conversion core
    input  wire logic                     convertStartN,
    output logic                          adcStart,
    input  wire logic                     adcDone,
    input  wire logic [acr_pkg::DATA_W-1:0] adcResult,
    input  wire logic                     adcChannel,
    // serial link
    input  wire logic                     serialClk,
    input  wire logic                     chipSelectN,
    output logic                          serialDataOut,
    output logic                          serialDataOe,
    // shared status / chain data pin
    input  wire logic                     statusPinIn,
    output logic                          statusPinOut,
    output logic                          statusPinOe
);
    import acr_pkg::*;

    // ------------------------------------------------------------
    // reset combination
    // ------------------------------------------------------------
    logic softReset;      // one-cycle software reset pulse
    logic sysRstN;        // power-on and software reset combined
    logic linkClrN;       // link clear: system reset or idle select
    logic next_softReset; // pulse next value

    assign sysRstN  = rst_n & ~softReset;
    assign linkClrN = sysRstN & ~chipSelectN;

    // write with reset bit low requests a software reset
    always_comb begin
        next_softReset = cfgWrite & ~cfgData[CFG_SOFT_RESET];
    end

    // reset pulse only answers power-on reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            softReset <= 1'b0;
        end else begin
            softReset <= next_softReset;
        end
    end

    // ------------------------------------------------------------
    // crossings from the pins and the link
    // ------------------------------------------------------------
    logic convStartSync; // synchronised start pin
    logic convStartPrev; // previous start level
    logic csActive;      // chip select low, core view
    logic frameLoaded;   // link took a snapshot
    logic loadToggle;    // link event toggle

    acr_sync #(.RESET_VAL(1'b1)) u_conv_sync (
        .clk     (core_clk),
        .rst_n   (sysRstN),
        .asyncIn (convertStartN),
        .syncOut (convStartSync)
    );

    acr_sync #(.RESET_VAL(1'b0)) u_cs_sync (
        .clk     (core_clk),
        .rst_n   (sysRstN),
        .asyncIn (~chipSelectN),
        .syncOut (csActive)
    );

    acr_pulse_sync u_load_sync (
        .clk      (core_clk),
        .rst_n    (sysRstN),
        .toggleIn (loadToggle),
        .pulseOut (frameLoaded)
    );

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    logic [CFG_W-1:0] next_config; // config next value
    logic             next_pinOe;  // status pin drive next value

    // writes land unless they ask for reset
    always_comb begin
        next_config = configRegister;
        if (cfgWrite && cfgData[CFG_SOFT_RESET]) begin
            next_config = cfgData;
        end
        // pin drives status only when chaining is off
        next_pinOe = next_config[CFG_CHAIN];
    end

    // defaults are all ones after either reset
    always_ff @(posedge core_clk or negedge sysRstN) begin
        if (!sysRstN) begin
            configRegister <= CFG_RESET;
            statusPinOe    <= 1'b1;
        end else begin
            configRegister <= next_config;
            statusPinOe    <= next_pinOe;
        end
    end

    // ------------------------------------------------------------
    // conversion control state machine
    // ------------------------------------------------------------
    acr_state_t          state;        // control state
    acr_state_t          next_state;   // state next value
    logic [DATA_W-1:0]   result;       // last conversion result
    logic                resultChan;   // channel of last result
    logic [DATA_W-1:0]   next_result;  // result next value
    logic                next_chan;    // channel next value
    logic                next_start;   // start pulse next value
    logic                next_busy;    // status level next value
    logic                startFall;    // start pin fell

    assign startFall = convStartPrev & ~convStartSync;

    // start on falling start pin, capture on done
    always_comb begin
        next_state  = state;
        next_result = result;
        next_chan   = resultChan;
        next_start  = 1'b0;
        unique case (state)
            ST_IDLE: begin
                // result held unless a start is seen
                if (startFall) begin
                    next_start = 1'b1;
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                // new result only from a started conversion
                if (adcDone) begin
                    next_result = adcResult;
                    next_chan   = adcChannel;
                    next_state  = ST_IDLE;
                end
            end
        endcase
        next_busy = (next_state == ST_CONVERT);
    end

    // any reset returns to idle
    always_ff @(posedge core_clk or negedge sysRstN) begin
        if (!sysRstN) begin
            state         <= ST_IDLE;
            result        <= '0;
            resultChan    <= 1'b0;
            adcStart      <= 1'b0;
            statusPinOut  <= 1'b0;
            convStartPrev <= 1'b1;
        end else begin
            state         <= next_state;
            result        <= next_result;
            resultChan    <= next_chan;
            adcStart      <= next_start;
            statusPinOut  <= next_busy;
            convStartPrev <= convStartSync;
        end
    end

    // ------------------------------------------------------------
    // frame snapshot handed to the link
    // ------------------------------------------------------------
    logic                resetPending; // next frame sends all ones
    logic [FRAME_W-1:0]  snapWord;     // frame image, left aligned
    logic                snapTag;      // frame uses 24 clocks
    logic                snapChain;    // frame forwards chain input
    logic                next_pending; // pending next value
    logic [FRAME_W-1:0]  next_snapWord; // image next value
    logic                next_snapTag;  // tag next value
    logic                next_snapChain; // chain next value

    // snapshot frozen while a frame is running
    always_comb begin
        next_pending   = resetPending;
        next_snapWord  = snapWord;
        next_snapTag   = snapTag;
        next_snapChain = snapChain;
        // first loaded frame consumes the all-ones image
        if (frameLoaded) begin
            next_pending = 1'b0;
        end
        if (!csActive) begin
            next_snapTag   = configRegister[CFG_TAG];
            next_snapChain = ~configRegister[CFG_CHAIN];
            if (next_pending) begin
                next_snapWord = FRAME_ONES;
            end else begin
                // data, then tag, then zeros
                next_snapWord = {result, resultChan,
                                 {ZERO_W{1'b0}}};
                if (!configRegister[CFG_TAG]) begin
                    next_snapWord = {result, {PAD_W{1'b0}}};
                end
            end
        end
    end

    // reset arms the all-ones frame
    always_ff @(posedge core_clk or negedge sysRstN) begin
        if (!sysRstN) begin
            resetPending <= 1'b1;
            snapWord     <= FRAME_ONES;
            snapTag      <= 1'b0;
            snapChain    <= 1'b0;
        end else begin
            resetPending <= next_pending;
            snapWord     <= next_snapWord;
            snapTag      <= next_snapTag;
            snapChain    <= next_snapChain;
        end
    end

    // ------------------------------------------------------------
    // link side output register
    // ------------------------------------------------------------
    logic               started;      // snapshot taken this frame
    logic [FRAME_W-1:0] shiftReg;     // output shift register
    logic               next_started; // started next value
    logic [FRAME_W-1:0] next_shift;   // shift next value
    logic               next_sdo;     // data out next value
    logic               next_toggle;  // load toggle next value
    logic               inBit;        // bit entering the lsb end, or bit 8 in short frames

    // shift one step; short frames insert after the data field
    function automatic logic [FRAME_W-1:0] shiftStep(
        input logic [FRAME_W-1:0] cur,
        input logic               bitIn,
        input logic               longFrame
    );
        logic [FRAME_W-1:0] res;
        res = {cur[FRAME_W-2:0], bitIn};
        if (!longFrame) begin
            res = {cur[FRAME_W-2:PAD_W], bitIn, {PAD_W{1'b0}}};
        end
        return res;
    endfunction

    // chain input in chain mode, own word recirculates otherwise
    always_comb begin
        inBit = snapChain ? statusPinIn : shiftReg[FRAME_W-1];
        next_started = 1'b1;
        next_toggle  = loadToggle;
        if (!started) begin
            // own word is the first word of every frame
            next_shift  = snapWord;
            next_sdo    = snapWord[FRAME_W-1];
            next_toggle = ~loadToggle;
        end else begin
            next_shift = shiftStep(shiftReg, inBit, snapTag);
            next_sdo   = shiftReg[FRAME_W-2];
        end
    end

    // cleared while chip select is high
    always_ff @(posedge serialClk or negedge linkClrN) begin
        if (!linkClrN) begin
            started       <= 1'b0;
            shiftReg      <= '0;
            serialDataOut <= 1'b0;
            serialDataOe  <= 1'b0;
        end else begin
            started       <= next_started;
            shiftReg      <= next_shift;
            serialDataOut <= next_sdo;
            serialDataOe  <= next_started;
        end
    end

    // load event survives across frames
    always_ff @(posedge serialClk or negedge sysRstN) begin
        if (!sysRstN) begin
            loadToggle <= 1'b0;
        end else begin
            loadToggle <= next_toggle;
        end
    end

endmodule

// ---- hdl/acr_pkg.sv ----
package acr_pkg;

    // ------------------------------------------------------------
    // configuration register layout
    // ------------------------------------------------------------
    localparam int          CFG_W          = 12;      // config width
    localparam logic [11:0] CFG_RESET      = 12'hfff; // all ones default
    localparam int          CFG_SOFT_RESET = 0;       // 0 = reset request
    localparam int          CFG_TAG        = 1;       // tag enable
    localparam int          CFG_CHAIN      = 5;       // 0 = chain input
    localparam int          CFG_AUTO       = 11;      // auto channel

    // ------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------
    localparam int          DATA_W     = 16;          // result width
    localparam int          FRAME_W    = 24;          // tagged frame
    localparam int          PAD_W      = FRAME_W - DATA_W; // bits after lsb
    localparam int          ZERO_W     = PAD_W - 1;   // zeros after tag
    localparam logic [23:0] FRAME_ONES = 24'hffffff;  // post-reset frame

    // ------------------------------------------------------------
    // core control states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_CONVERT
    } acr_state_t;

endpackage

// ---- hdl/acr_sync.sv ----
// ------------------------------------------------------------
// two-flop level synchroniser
// ------------------------------------------------------------
module acr_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic asyncIn,
    output logic      syncOut
);

    logic stage1; // metastable stage, read only by syncOut

    // plain two-stage register chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1  <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule

// ---- hdl/acr_pulse_sync.sv ----
// ------------------------------------------------------------
// toggle to pulse crossing into the destination clock
// ------------------------------------------------------------
module acr_pulse_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic toggleIn,
    output logic      pulseOut
);

    logic toggleSync; // synchronised toggle level
    logic togglePrev; // last seen toggle level
    logic next_pulse; // pulse next value

    acr_sync #(.RESET_VAL(1'b0)) u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn (toggleIn),
        .syncOut (toggleSync)
    );

    // any change of the toggle is one event
    always_comb begin
        next_pulse = toggleSync ^ togglePrev;
    end

    // register edge history and pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            togglePrev <= 1'b0;
            pulseOut   <= 1'b0;
        end else begin
            togglePrev <= toggleSync;
            pulseOut   <= next_pulse;
        end
    end

endmodule

// ---- bench/acr_readout_chk.sv ----
// ----------------------------------------
// readout checker
// ----------------------------------------
module acr_readout_chk
    import acr_pkg::*;
(
    input wire logic                      core_clk,
    input wire logic                      rst_n,
    input wire logic                      cfgWrite,
    input wire logic [acr_pkg::CFG_W-1:0] cfgData,
    input wire logic [acr_pkg::CFG_W-1:0] configRegister,
    input wire logic                      convertStartN,
    input wire logic                      adcStart,
    input wire logic                      serialClk,
    input wire logic                      chipSelectN,
    input wire logic                      serialDataOut,
    input wire logic                      serialDataOe,
    input wire logic                      statusPinIn,
    input wire logic                      statusPinOut,
    input wire logic                      statusPinOe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0]  cnt;  // rises in frame
    logic [23:0] inH;  // chain input history
    logic [23:0] outH; // output history
    logic        rdy;  // conversion started since reset
    // rise counter and input history, cleared between frames
    always_ff @(posedge serialClk or posedge chipSelectN) begin
        if (chipSelectN) begin
            cnt <= 8'h00;
            inH <= 24'h000000;
        end else begin
            cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
            inH <= {inH[22:0], statusPinIn};
        end
    end
    // output history at the sampling edge
    always_ff @(negedge serialClk or posedge chipSelectN) begin
        if (chipSelectN) outH <= 24'h000000;
        else outH <= {outH[22:0], serialDataOut};
    end
    // set by a conversion, cleared by any reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) rdy <= 1'b0;
        else if (cfgWrite && !cfgData[CFG_SOFT_RESET]) rdy <= 1'b0;
        else if (adcStart) rdy <= 1'b1;
    end
    sequence softReq;
        cfgWrite && !cfgData[CFG_SOFT_RESET];
    endsequence
    sequence cfgBack;
        ##[1:3] configRegister == CFG_RESET;
    endsequence
    AST_SOFT_RESET: assert property (
        @(posedge core_clk) disable iff (!rst_n) softReq |-> cfgBack)
        else $error("soft reset did not restore config");
    AST_CFG_STORE: assert property (
        @(posedge core_clk) disable iff (!rst_n) cfgWrite && cfgData[0]
        |=> configRegister == $past(cfgData))
        else $error("config write not stored");
    AST_PIN_ROLE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        statusPinOe == configRegister[CFG_CHAIN])
        else $error("status pin role wrong");
    AST_START_CAUSE: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(adcStart) |-> !$past(convertStartN, 3))
        else $error("start without start pin");
    AST_BUSY: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        adcStart |-> statusPinOut ##1 !adcStart)
        else $error("start pulse or busy wrong");
    AST_OE_OFF: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        chipSelectN && $past(chipSelectN) |-> !serialDataOe && !serialDataOut)
        else $error("output not released");
    AST_OE_ON: assert property (
        @(negedge serialClk) disable iff (!rst_n || chipSelectN)
        cnt != 8'h00 |-> serialDataOe)
        else $error("output not driven in frame");
    AST_TAG_ZEROS: assert property (
        @(negedge serialClk) disable iff (!rst_n || chipSelectN)
        rdy && configRegister[CFG_TAG] && cnt inside {[18:24]}
        |-> !serialDataOut)
        else $error("trailing bits not zero");
    AST_REPEAT: assert property (
        @(negedge serialClk) disable iff (!rst_n || chipSelectN)
        configRegister[CFG_CHAIN]
        && cnt > (configRegister[CFG_TAG] ? 8'h18 : 8'h10)
        |-> serialDataOut == (configRegister[CFG_TAG] ? outH[23] : outH[15]))
        else $error("own word not repeated");
    AST_CHAIN_SHIFT: assert property (
        @(negedge serialClk) disable iff (!rst_n || chipSelectN)
        !configRegister[CFG_CHAIN]
        && cnt > (configRegister[CFG_TAG] ? 8'h18 : 8'h10)
        |-> serialDataOut == (configRegister[CFG_TAG] ? inH[23] : inH[15]))
        else $error("chain data delay wrong");
endmodule
bind acr_readout acr_readout_chk u_chk (.core_clk, .rst_n, .cfgWrite,
    .cfgData, .configRegister, .convertStartN, .adcStart, .serialClk,
    .chipSelectN, .serialDataOut, .serialDataOe, .statusPinIn,
    .statusPinOut, .statusPinOe);

// ---- bench/acr_host_model.sv ----
// ----------------------------------------
// host and upstream converter model
// ----------------------------------------
module acr_host_model (
    input  wire logic serialDataOut,
    output logic      serialClk,
    output logic      chipSelectN,
    output logic      statusPinIn
);
    timeunit 1ns;
    timeprecision 100ps;
    // link clock stands still outside frames
    initial begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        statusPinIn = 1'b0;
    end
    // one frame of n clocks, up is the upstream stream
    task automatic frame(input int n, input logic [47:0] up,
                         output logic [47:0] got);
        got = 48'h0;
        chipSelectN = 1'b0; // low for the whole transfer
        #40;
        for (int k = 1; k <= n; k++) begin
            serialClk = 1'b1; // 64 ns period, slow link
            #2 statusPinIn = up[n-k]; // regular upstream shifts
            #30 serialClk = 1'b0;
            got[n-k] = serialDataOut; // sample on falling edge
            #32;
        end
        chipSelectN = 1'b1;
        statusPinIn = ~statusPinIn; // released line holds no data
        #48;
    endtask
endmodule

// ---- bench/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import acr_pkg::*;
    // ----------------------------------------
    // signals and model state
    // ----------------------------------------
    logic        core_clk = 1'b0, rst_n = 1'b0, cfgWrite = 1'b0;
    logic [11:0] cfgData = 12'hfff, configRegister;
    logic        convertStartN = 1'b1, adcDone = 1'b0, adcChannel = 1'b0;
    logic [15:0] adcResult = 16'h0000, resM;
    logic        adcStart, serialClk, chipSelectN, serialDataOut;
    logic        serialDataOe, statusPinIn, statusPinOut, statusPinOe;
    logic        chM, tagM, chainM, onesM;
    int          failures = 0, check_count = 0;
    logic [11:0] modes [4] = '{12'h7fd, 12'hfff, 12'hfdd, 12'hfdf};
    always #4 core_clk = ~core_clk;
    acr_readout u_acr_readout (.core_clk(core_clk), .rst_n(rst_n),
        .cfgWrite(cfgWrite), .cfgData(cfgData),
        .configRegister(configRegister), .convertStartN(convertStartN),
        .adcStart(adcStart), .adcDone(adcDone), .adcResult(adcResult),
        .adcChannel(adcChannel), .serialClk(serialClk),
        .chipSelectN(chipSelectN), .serialDataOut(serialDataOut),
        .serialDataOe(serialDataOe), .statusPinIn(statusPinIn),
        .statusPinOut(statusPinOut), .statusPinOe(statusPinOe));
    acr_host_model u_acr_host_model (.serialDataOut(serialDataOut),
        .serialClk(serialClk), .chipSelectN(chipSelectN),
        .statusPinIn(statusPinIn));
    // compare and count
    task automatic check(input string what, input logic [47:0] exp,
                         input logic [47:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // expected frame: own word, then upstream or own repeated
    function automatic logic [47:0] expect_frame(int n, logic [47:0] up);
        logic [23:0] own;
        logic [47:0] e;
        bit          q[$];
        int          len;
        len = tagM ? 24 : 16;
        own = onesM ? 24'hffffff : tagM ? {resM, chM, 7'h00} : {8'h0, resM};
        e = 48'h0;
        for (int i = len - 1; i >= 0; i--)
            q.push_back(own[i]);
        while (q.size() < n)
            q.push_back(chainM ? up[n - 1 - q.size() + len]
                               : q[q.size() - len]);
        for (int i = 0; i < n; i++)
            e[n - 1 - i] = q[i];
        return e;
    endfunction
    task automatic run_frame(input int n);
        logic [47:0] up;
        logic [47:0] got;
        up = 48'({$urandom(), $urandom()});
        u_acr_host_model.frame(n, up, got);
        check("serial frame", expect_frame(n, up), got);
    endtask
    // config write; bit 0 low requests a soft reset
    task automatic cfg(input logic [11:0] d);
        logic [11:0] v;
        @(negedge core_clk) cfgWrite = 1'b1;
        cfgData = d;
        @(negedge core_clk) cfgWrite = 1'b0;
        repeat (4) @(negedge core_clk);
        v = d[CFG_SOFT_RESET] ? d : 12'hfff;
        tagM = v[CFG_TAG];
        chainM = !v[CFG_CHAIN];
        onesM = onesM | !d[CFG_SOFT_RESET];
        check("config", 48'(v), 48'(configRegister));
        check("pin role", 48'(v[CFG_CHAIN]), 48'(statusPinOe));
    endtask
    // conversion through the start pin and the core strobe
    task automatic convert(input logic [15:0] res, input logic ch);
        int w;
        @(negedge core_clk) convertStartN = 1'b0;
        for (w = 0; w < 20 && adcStart !== 1'b1; w++)
            @(negedge core_clk);
        check("start seen", 48'h1, 48'(w < 20));
        check("busy high", 48'h1, 48'(statusPinOut));
        @(negedge core_clk) adcResult = res;
        adcChannel = ch;
        adcDone = 1'b1;
        @(negedge core_clk) adcDone = 1'b0;
        convertStartN = 1'b1;
        repeat (4) @(negedge core_clk);
        check("busy low", 48'h0, 48'(statusPinOut));
        // a done pulse while idle must leave the result alone
        adcResult = ~res;
        adcDone = 1'b1;
        @(negedge core_clk) adcDone = 1'b0;
        resM = res;
        chM = ch;
        onesM = 1'b0;
    endtask
    task automatic hard_reset(input int cyc);
        @(negedge core_clk) rst_n = 1'b0;
        repeat (cyc) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        {onesM, tagM, chainM} = 3'b110;
        check("reset config", 48'hfff, 48'(configRegister));
        check("reset pin", 48'h1, 48'(statusPinOe));
        run_frame(24);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        void'($urandom(89582));
        hard_reset(20);
        $display("test reset done");
        foreach (modes[i]) begin
            cfg(modes[i]);
            convert(16'($urandom()), i[0] ^ i[1]);
            run_frame(tagM ? 48 : 32);
            run_frame(tagM ? 24 : 16);
            run_frame(tagM ? 24 : 16);
            $display("test mode %0d done", i);
        end
        cfg(12'hffe);
        run_frame(24);
        convert(16'h8001, 1'b1);
        run_frame(24);
        $display("test soft reset done");
        cfg(12'hfdd);
        hard_reset(3);
        $display("test second reset done");
        summarize();
    end
    // watchdog against a hang
    initial begin
        #200000;
        failures++;
        summarize();
    end
endmodule
